// ---- rtl/ssrx_pkg.sv ----
// ----------------------------------------------------------------------------
// shared constants and carriers of the receive status register block
// ----------------------------------------------------------------------------
package ssrx_pkg;

    // ------------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFS_RX_CTRL   = 8'h0c;  // receive control
    localparam logic [7:0] OFS_INT_STAT  = 8'h14;  // interrupt status / clear
    localparam logic [7:0] OFS_RECEIVED_WORD_TALLY  = 8'h18;  // received word counter
    localparam logic [7:0] OFS_TX_FIFO   = 8'h20;  // transmit fifo port
    localparam logic [7:0] OFS_RX_FIFO   = 8'h24;  // receive fifo port
    localparam logic [7:0] OFS_DIR_TERM  = 8'h28;  // direction and termination
    localparam logic [7:0] OFS_SWITCH    = 8'h44;  // user switch read

    // ------------------------------------------------------------------------
    // receive control fields
    // ------------------------------------------------------------------------
    localparam int RXC_TEST  = 7;                  // loopback test mode
    localparam int RXC_FPOL  = 6;                  // filter polarity
    localparam int RXC_FIEN  = 5;                  // filter interrupt enable
    localparam int RXC_FEN   = 4;                  // filter enable
    localparam int RXC_OVIEN = 3;                  // overflow interrupt enable
    localparam int RXC_AFIEN = 2;                  // almost-full interrupt enable
    localparam int RXC_RXIEN = 1;                  // receive interrupt enable
    localparam int RXC_ENA   = 0;                  // receiver enable
    localparam logic [7:0] RXC_RESET = 8'h00;

    // ------------------------------------------------------------------------
    // status read fields and clear write fields
    // ------------------------------------------------------------------------
    localparam int ST_IRQ    = 15;
    localparam int ST_FAE    = 12;
    localparam int ST_TXI    = 11;
    localparam int ST_TXFULL = 10;
    localparam int ST_TXAE   = 9;
    localparam int ST_TXMT   = 8;
    localparam int ST_OVF    = 5;
    localparam int ST_FAF    = 4;
    localparam int ST_RXI    = 3;
    localparam int ST_RXFULL = 2;
    localparam int ST_RXAF   = 1;
    localparam int ST_RXMT   = 0;
    localparam int CLR_OVF   = 4;
    localparam int CLR_RXI   = 3;
    localparam int CLR_TXI   = 2;
    localparam int CLR_FAF   = 1;
    localparam int CLR_FAE   = 0;

    // ------------------------------------------------------------------------
    // direction / termination, lines, words
    // ------------------------------------------------------------------------
    localparam int DIR_LSB  = 0;
    localparam int DIR_W    = 9;
    localparam int TERM_LSB = 16;
    localparam int TERM_W   = 8;
    localparam logic [8:0]  DIR_RESET  = 9'h000;
    localparam logic [7:0]  TERM_RESET = 8'h00;
    localparam int LINE_N   = 20;
    localparam logic [19:0] LINE_INPUT_MASK = 20'h0f001;  // io 0 and io 12-15
    localparam int WORD_W   = 18;                 // serial word width
    localparam int MODE_BIT = 17;                 // mode bit within a word
    localparam int CNT_W    = 16;
    localparam int SW_W     = 6;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic        FLAG_D_RESET = 1'b1;  // edge memories start high, no false edge after reset

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        wr;                          // write strobe
        logic        rd;                          // read strobe
        logic [7:0]  addr;                        // byte offset
        logic [31:0] wdata;                       // write data
    } ssrx_host_req_s;

    typedef struct packed {
        logic ovf;                                // receive overflow
        logic faf;                                // rx almost-full rise
        logic rxi;                                // word received
        logic txi;                                // transmit done
        logic fae;                                // tx almost-empty fall-in
    } ssrx_evt_s;

endpackage : ssrx_pkg

// ---- rtl/ssrx_regs.sv ----
`timescale 1ns/10ps

module ssrx_regs (
    input  wire logic                   i_ref_clk,            // 200 mhz host bus clock
    input  wire logic                   i_reset,              // synchronous, active high
    // host register port
    input  wire ssrx_pkg::ssrx_host_req_s i_host_req,         // one access per strobe
    output logic [31:0]                 o_host_rdata,         // read data, registered
    output logic                        o_host_rvalid,        // one cycle after read strobe
    // interrupt
    input  wire logic                   i_int_master_en,      // master interrupt enable
    input  wire logic                   i_tx_int_en,          // transmit done enable
    input  wire logic                   i_tx_ae_int_en,       // tx almost-empty enable
    output logic                        o_int_req,            // host interrupt line
    // transmit state machine
    input  wire logic                   i_tx_start_req,       // pulse: software sets start
    input  wire logic                   i_tx_msg_end,         // pulse: message finished
    output logic                        o_tx_start,           // start bit state
    output logic                        o_tx_go,              // start with data present
    // transmit fifo
    input  wire logic                   i_txf_full,
    input  wire logic                   i_txf_almost_empty,
    input  wire logic                   i_txf_empty,
    output logic                        o_txf_wr,             // push pulse
    output logic [31:0]                 o_txf_wr_data,        // registered push data
    output logic                        o_txf_rd,             // pop pulse
    input  wire logic [31:0]            i_txf_rd_data,        // head word
    // serial receiver
    input  wire logic                   i_rx_word_valid,
    input  wire logic [17:0]            i_rx_word,
    output logic                        o_rx_word_ready,
    output logic                        o_rx_enable,          // receiver enable bit
    // receive fifo
    input  wire logic                   i_rxf_full,
    input  wire logic                   i_rxf_almost_full,
    input  wire logic                   i_rxf_empty,
    output logic                        o_rxf_wr_valid,
    output logic [31:0]                 o_rxf_wr_data,
    input  wire logic                   i_rxf_wr_ready,
    output logic                        o_rxf_rd,             // pop pulse
    input  wire logic [31:0]            i_rxf_rd_data,        // head word
    // line transceivers and switch
    output logic [19:0]                 o_line_oe_n,          // low = driven
    output logic [7:0]                  o_line_term,          // high = terminated
    input  wire logic [5:0]             i_user_switch_bit     // switch pins, async
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       rx_ctrl;                // receive control
        logic [8:0]       dir;                    // direction bits, inert
        logic [7:0]       term;                   // termination bits
        ssrx_pkg::ssrx_evt_s evt;                 // latched events
        logic             tx_start;               // start bit
        logic             txae_d;                 // last tx almost-empty flag
        logic             rxaf_d;                 // last rx almost-full flag
        logic [15:0]      tally;                  // received word tally
        logic             tally_hold;             // clear pending, old count shown
        logic [1:0][31:0] buf_data;               // two-entry rx buffer
        logic             buf_wp;
        logic             buf_rp;
        logic [1:0]       buf_cnt;
        logic [31:0]      rdata;
        logic             rvalid;
        logic             txf_wr;
        logic [31:0]      txf_data;
        logic [5:0]       sw_s1;                  // synchroniser first stage
        logic [5:0]       sw_s2;                  // synchroniser second stage
    } ssrx_state_s;

    ssrx_state_s state_reg;                       // registered state
    ssrx_state_s state_next;                      // next state

    // ------------------------------------------------------------------------
    // decode and datapath terms
    // ------------------------------------------------------------------------
    logic        wr_rxc;                          // write receive control
    logic        wr_stat;                         // write status clear
    logic        wr_cnt;                          // write counter
    logic        wr_txf;                          // write tx port
    logic        wr_rxf;                          // write rx port
    logic        wr_dir;                          // write direction/termination
    logic        rd_txf;                          // read tx port
    logic        rd_rxf;                          // read rx port
    logic        src_v;                           // word offered to rx path
    logic [31:0] src_d;                           // that word
    logic        mode_match;                      // mode bit equals polarity
    logic        keep;                            // word passes filter
    logic        buf_full;
    logic        push;
    logic        pop;
    logic        tally_clr;
    logic        irq;                             // combined request
    logic [15:0] stat_word;
    ssrx_pkg::ssrx_evt_s set_evt;
    ssrx_pkg::ssrx_evt_s clr_evt;
    ssrx_pkg::ssrx_evt_s en_evt;

    // ------------------------------------------------------------------------
    // host access decode
    // ------------------------------------------------------------------------
    assign wr_rxc  = i_host_req.wr && (i_host_req.addr == ssrx_pkg::OFS_RX_CTRL);
    assign wr_stat = i_host_req.wr && (i_host_req.addr == ssrx_pkg::OFS_INT_STAT);
    assign wr_cnt  = i_host_req.wr && (i_host_req.addr == ssrx_pkg::OFS_RECEIVED_WORD_TALLY);
    assign wr_txf  = i_host_req.wr && (i_host_req.addr == ssrx_pkg::OFS_TX_FIFO);
    assign wr_rxf  = i_host_req.wr && (i_host_req.addr == ssrx_pkg::OFS_RX_FIFO);
    assign wr_dir  = i_host_req.wr && (i_host_req.addr == ssrx_pkg::OFS_DIR_TERM);
    assign rd_txf  = i_host_req.rd && (i_host_req.addr == ssrx_pkg::OFS_TX_FIFO);
    assign rd_rxf  = i_host_req.rd && (i_host_req.addr == ssrx_pkg::OFS_RX_FIFO);

    // reading a fifo port pops its head, the word leaves for good
    assign o_txf_rd = rd_txf;
    assign o_rxf_rd = rd_rxf;

    // ------------------------------------------------------------------------
    // receive source, filter and overflow
    // ------------------------------------------------------------------------
    assign buf_full = (state_reg.buf_cnt == 2'd2);

    // serial words are taken only when enabled, not in loopback, with room
    assign o_rx_enable     = state_reg.rx_ctrl[ssrx_pkg::RXC_ENA];
    assign o_rx_word_ready = state_reg.rx_ctrl[ssrx_pkg::RXC_ENA]
                           && !state_reg.rx_ctrl[ssrx_pkg::RXC_TEST]
                           && !buf_full;

    always_comb begin
        // loopback swaps the serial receiver for host writes
        if (state_reg.rx_ctrl[ssrx_pkg::RXC_TEST]) begin
            src_v = wr_rxf;
            src_d = i_host_req.wdata;
        end else begin
            src_v = i_rx_word_valid && o_rx_word_ready;
            src_d = {14'h0000, i_rx_word};
        end
    end

    assign mode_match = (src_d[ssrx_pkg::MODE_BIT] == state_reg.rx_ctrl[ssrx_pkg::RXC_FPOL]);
    assign keep       = src_v && (!state_reg.rx_ctrl[ssrx_pkg::RXC_FEN] || mode_match);
    // a word that would land in a full fifo is counted as overflow and dropped;
    // a full buffer only drops words in loopback, serial words are stalled instead
    assign set_evt.ovf = keep && (i_rxf_full || buf_full);
    assign push        = keep && !set_evt.ovf;
    assign pop         = (state_reg.buf_cnt != 2'd0) && i_rxf_wr_ready;

    // ------------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------------
    assign set_evt.rxi = src_v && (!state_reg.rx_ctrl[ssrx_pkg::RXC_FIEN] || mode_match);
    assign set_evt.faf = i_rxf_almost_full && !state_reg.rxaf_d;
    assign set_evt.fae = i_txf_almost_empty && !state_reg.txae_d;
    assign set_evt.txi = state_reg.tx_start && i_tx_msg_end;

    assign clr_evt.ovf = wr_stat && i_host_req.wdata[ssrx_pkg::CLR_OVF];
    assign clr_evt.rxi = wr_stat && i_host_req.wdata[ssrx_pkg::CLR_RXI];
    assign clr_evt.txi = wr_stat && i_host_req.wdata[ssrx_pkg::CLR_TXI];
    assign clr_evt.faf = wr_stat && i_host_req.wdata[ssrx_pkg::CLR_FAF];
    assign clr_evt.fae = wr_stat && i_host_req.wdata[ssrx_pkg::CLR_FAE];

    // individual enables sit after the latches, so status shows regardless
    assign en_evt.ovf = state_reg.rx_ctrl[ssrx_pkg::RXC_OVIEN];
    assign en_evt.faf = state_reg.rx_ctrl[ssrx_pkg::RXC_AFIEN];
    assign en_evt.rxi = state_reg.rx_ctrl[ssrx_pkg::RXC_RXIEN];
    assign en_evt.txi = i_tx_int_en;
    assign en_evt.fae = i_tx_ae_int_en;

    assign irq       = |(state_reg.evt & en_evt);
    assign o_int_req = irq && i_int_master_en;

    // ------------------------------------------------------------------------
    // status word seen on read
    // ------------------------------------------------------------------------
    always_comb begin
        stat_word                      = 16'h0000;
        stat_word[ssrx_pkg::ST_IRQ]    = irq;
        stat_word[ssrx_pkg::ST_FAE]    = state_reg.evt.fae;
        stat_word[ssrx_pkg::ST_TXI]    = state_reg.evt.txi;
        stat_word[ssrx_pkg::ST_TXFULL] = i_txf_full;
        stat_word[ssrx_pkg::ST_TXAE]   = i_txf_almost_empty;
        stat_word[ssrx_pkg::ST_TXMT]   = i_txf_empty;
        stat_word[ssrx_pkg::ST_OVF]    = state_reg.evt.ovf;
        stat_word[ssrx_pkg::ST_FAF]    = state_reg.evt.faf;
        stat_word[ssrx_pkg::ST_RXI]    = state_reg.evt.rxi;
        stat_word[ssrx_pkg::ST_RXFULL] = i_rxf_full;
        stat_word[ssrx_pkg::ST_RXAF]   = i_rxf_almost_full;
        stat_word[ssrx_pkg::ST_RXMT]   = i_rxf_empty;
    end

    // counter clears on a disabled receiver or any write to its address
    assign tally_clr = !state_reg.rx_ctrl[ssrx_pkg::RXC_ENA] || wr_cnt;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = 1'b0;
        state_next.txf_wr = 1'b0;

        // switch pins come from outside, two stages before use
        state_next.sw_s1 = i_user_switch_bit;
        state_next.sw_s2 = state_reg.sw_s1;

        // control registers
        if (wr_rxc) begin
            state_next.rx_ctrl = i_host_req.wdata[7:0];
        end
        if (wr_dir) begin
            state_next.dir  = i_host_req.wdata[ssrx_pkg::DIR_LSB +: ssrx_pkg::DIR_W];
            state_next.term = i_host_req.wdata[ssrx_pkg::TERM_LSB +: ssrx_pkg::TERM_W];
        end

        // start bit: a fresh request beats the end of the previous message
        state_next.tx_start = i_tx_start_req || (state_reg.tx_start && !i_tx_msg_end);

        // transmit port write, data held for the fifo
        if (wr_txf) begin
            state_next.txf_wr   = 1'b1;
            state_next.txf_data = i_host_req.wdata;
        end

        // edge memories for the level flags
        state_next.txae_d = i_txf_almost_empty;
        state_next.rxaf_d = i_rxf_almost_full;

        // latched events, a set in the clearing cycle wins
        state_next.evt = set_evt | (state_reg.evt & ~clr_evt);

        // two-entry buffer between source and receive fifo
        if (push) begin
            state_next.buf_data[state_reg.buf_wp] = src_d;
            state_next.buf_wp = !state_reg.buf_wp;
        end
        if (pop) begin
            state_next.buf_rp = !state_reg.buf_rp;
        end
        case ({push, pop})
            2'b10:   state_next.buf_cnt = state_reg.buf_cnt + 2'd1;
            2'b01:   state_next.buf_cnt = state_reg.buf_cnt - 2'd1;
            default: state_next.buf_cnt = state_reg.buf_cnt;
        endcase

        // word tally: old count stays visible until the next stored word
        if (tally_clr) begin
            state_next.tally_hold = 1'b1;
        end else if (pop) begin
            state_next.tally_hold = 1'b0;
            if (state_reg.tally_hold) begin
                state_next.tally = 16'h0001;
            end else begin
                state_next.tally = state_reg.tally + 16'h0001;
            end
        end

        // register reads, one cycle latency
        if (i_host_req.rd) begin
            state_next.rvalid = 1'b1;
            case (i_host_req.addr)
                ssrx_pkg::OFS_RX_CTRL:  state_next.rdata = {24'h000000, state_reg.rx_ctrl};
                ssrx_pkg::OFS_INT_STAT: state_next.rdata = {16'h0000, stat_word};
                ssrx_pkg::OFS_RECEIVED_WORD_TALLY: state_next.rdata = {16'h0000, state_reg.tally};
                ssrx_pkg::OFS_TX_FIFO:  state_next.rdata = i_txf_rd_data;
                ssrx_pkg::OFS_RX_FIFO:  state_next.rdata = i_rxf_rd_data;
                ssrx_pkg::OFS_DIR_TERM: state_next.rdata = {8'h00, state_reg.term, 7'h00, state_reg.dir};
                ssrx_pkg::OFS_SWITCH:   state_next.rdata = {26'h0000000, state_reg.sw_s2};
                default:                state_next.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_reg            <= '0;
            state_reg.rx_ctrl    <= ssrx_pkg::RXC_RESET;
            state_reg.dir        <= ssrx_pkg::DIR_RESET;
            state_reg.term       <= ssrx_pkg::TERM_RESET;
            state_reg.tally      <= ssrx_pkg::CNT_RESET;
            // a fifo that is already almost empty at reset has made no transition
            state_reg.txae_d     <= ssrx_pkg::FLAG_D_RESET;
            state_reg.rxaf_d     <= ssrx_pkg::FLAG_D_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign o_host_rdata   = state_reg.rdata;
    assign o_host_rvalid  = state_reg.rvalid;
    assign o_tx_start     = state_reg.tx_start;
    // transmit only runs once words are waiting in the fifo
    assign o_tx_go        = state_reg.tx_start && !i_txf_empty;
    assign o_txf_wr       = state_reg.txf_wr;
    assign o_txf_wr_data  = state_reg.txf_data;
    assign o_rxf_wr_valid = (state_reg.buf_cnt != 2'd0);
    assign o_rxf_wr_data  = state_reg.buf_data[state_reg.buf_rp];
    // fixed directions; the stored direction bits never reach the lines
    assign o_line_oe_n    = ssrx_pkg::LINE_INPUT_MASK;
    assign o_line_term    = state_reg.term;

endmodule : ssrx_regs

// ---- verification/ssrx_regs_assertions.sv ----
`timescale 1ns/10ps
module ssrx_regs_assertions (
    input wire logic                     i_ref_clk,
    input wire logic                     i_reset,
    input wire ssrx_pkg::ssrx_host_req_s i_host_req,
    input wire logic                     i_int_master_en,
    input wire logic                     i_tx_start_req,
    input wire logic                     i_tx_msg_end,
    input wire logic                     o_int_req,
    input wire logic                     o_tx_start,
    input wire logic                     o_txf_wr,
    input wire logic [31:0]              o_txf_wr_data,
    input wire logic                     o_txf_rd,
    input wire logic                     o_rxf_rd,
    input wire logic                     o_host_rvalid,
    input wire logic [19:0]              o_line_oe_n
);
    // one clock domain, so clocking and reset are stated once
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    chk_read_answer: assert property (i_host_req.rd |=> o_host_rvalid) else $error("read not answered");
    chk_master_gate: assert property (!i_int_master_en |-> !o_int_req) else $error("interrupt not masked");
    chk_start_clear: assert property (o_tx_start && i_tx_msg_end && !i_tx_start_req |=> !o_tx_start)
        else $error("start bit not cleared");
    chk_start_hold: assert property (o_tx_start && !i_tx_msg_end |=> o_tx_start) else $error("start bit lost");
    chk_tx_push: assert property (i_host_req.wr && i_host_req.addr == 8'h20
        |=> o_txf_wr && o_txf_wr_data == $past(i_host_req.wdata)) else $error("tx push wrong");
    chk_tx_pop: assert property (o_txf_rd == (i_host_req.rd && i_host_req.addr == 8'h20)) else $error("tx pop");
    chk_rx_pop: assert property (o_rxf_rd == (i_host_req.rd && i_host_req.addr == 8'h24)) else $error("rx pop");
    chk_line_dirs: assert property (o_line_oe_n == 20'h0f001) else $error("line direction wrong");
endmodule : ssrx_regs_assertions
bind ssrx_regs ssrx_regs_assertions u_chk (.*);

// ---- verification/ssrx_fifo_model.sv ----
`timescale 1ns/10ps
// receive fifo of depth 4; almost full from 3 words
module ssrx_fifo_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_stall,   // high = slow, refuses writes
    input  wire logic        i_wr,
    input  wire logic [31:0] i_data,
    input  wire logic        i_rd,
    output logic             o_ready,
    output logic [31:0]      o_head,
    output logic [2:0]       o_flags    // full, almost full, empty
);
    logic [31:0] q[$];
    logic [2:0]  n = 3'h0;
    assign o_ready = !i_stall;
    assign o_flags = {n == 3'h4, n >= 3'h3, n == 3'h0};
    // head shows all ones when empty, never a stale word
    always @(posedge i_ref_clk) begin
        if (i_reset) q = {};
        if (i_rd && q.size() > 0) q.pop_front();
        if (!i_reset && i_wr && o_ready && q.size() < 4) q.push_back(i_data);
        n <= 3'(q.size());
        o_head <= q.size() > 0 ? q[0] : 32'hffff_ffff;
    end
endmodule : ssrx_fifo_model

// ---- verification/ssrx_regs_test.sv ----
`timescale 1ns/10ps
module ssrx_regs_test;
    logic        i_ref_clk, i_reset, i_int_master_en, i_tx_int_en, i_tx_ae_int_en, i_tx_start_req, i_tx_msg_end;
    logic        i_txf_full, i_txf_almost_empty, i_txf_empty, i_rx_word_valid, i_rxf_full, i_rxf_almost_full;
    logic        i_rxf_empty, i_rxf_wr_ready, stall, o_host_rvalid, o_int_req, o_tx_start, o_tx_go, o_txf_wr;
    logic        o_txf_rd, o_rx_word_ready, o_rx_enable, o_rxf_wr_valid, o_rxf_rd;
    logic [31:0] o_host_rdata, o_txf_wr_data, i_txf_rd_data, o_rxf_wr_data, i_rxf_rd_data;
    logic [17:0] i_rx_word;
    logic [19:0] o_line_oe_n;
    logic [7:0]  o_line_term;
    logic [5:0]  i_user_switch_bit;
    ssrx_pkg::ssrx_host_req_s i_host_req;
    int          n_errors = 0;
    int          checks = 0;
    ssrx_regs u_dut (.*);
    ssrx_fifo_model u_rxf (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_stall(stall), .i_wr(o_rxf_wr_valid),
        .i_data(o_rxf_wr_data), .i_rd(o_rxf_rd), .o_ready(i_rxf_wr_ready), .o_head(i_rxf_rd_data),
        .o_flags({i_rxf_full, i_rxf_almost_full, i_rxf_empty}));
    initial begin
        i_ref_clk = 0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one host access; the strobe stands for exactly one edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk) i_host_req <= '{w, !w, a, d};
        @(posedge i_ref_clk) i_host_req <= '0;
        #1;
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), o_host_rdata, e);
    endtask : rd
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        n_errors++;
        test_done();
    end
    initial begin
        i_host_req = '0; stall = 0; i_reset = 1; i_rx_word = 18'h0; i_user_switch_bit = 6'h2a;
        {i_int_master_en, i_tx_int_en, i_tx_ae_int_en, i_tx_start_req, i_tx_msg_end} = 5'h0;
        {i_txf_full, i_txf_almost_empty, i_txf_empty, i_rx_word_valid} = 4'h2;
        i_txf_rd_data = 32'h0abc_1234;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 0;
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h101);
        acc(1'b1, 8'h28, 32'hffff_ffff);
        chk("term", o_line_term, 32'hff);
        rd(8'h28, 32'h00ff_01ff);
        acc(1'b1, 8'h0c, 32'hffff_ff81);
        rd(8'h0c, 32'h81);
        chk("rx enable", o_rx_enable, 1);
        @(posedge i_ref_clk) stall <= 1;
        acc(1'b1, 8'h24, 32'h2_0005);
        rd(8'h18, 32'h0);
        @(posedge i_ref_clk) stall <= 0;
        rd(8'h18, 32'h1);
        rd(8'h14, 32'h108);
        acc(1'b1, 8'h14, 32'h8);
        rd(8'h14, 32'h100);
        rd(8'h24, 32'h2_0005);
        acc(1'b1, 8'h18, 32'h0);
        rd(8'h18, 32'h1);
        // filter on mode one: five of ten pass, fifo holds four
        acc(1'b1, 8'h0c, 32'hd1);
        for (int k = 0; k < 10; k++) acc(1'b1, 8'h24, {14'h0, k[0], 17'(k)});
        rd(8'h18, 32'h4);
        rd(8'h14, 32'h13e);
        rd(8'h24, 32'h2_0001);
        acc(1'b1, 8'h14, 32'h1f);
        rd(8'h14, 32'h102);
        acc(1'b1, 8'h20, 32'h3_ffff);
        rd(8'h20, 32'h0abc_1234);
        @(posedge i_ref_clk) {i_int_master_en, i_tx_int_en, i_tx_start_req, i_txf_empty} <= 4'he;
        @(posedge i_ref_clk) {i_tx_start_req, i_tx_msg_end} <= 2'h1;
        #1 chk("tx go", o_tx_go, 1);
        @(posedge i_ref_clk) i_tx_msg_end <= 0;
        rd(8'h14, 32'h8802);
        chk("int line", o_int_req, 1);
        chk("tx start", o_tx_start, 0);
        // almost-empty event on entry only, not while the flag stays
        @(posedge i_ref_clk) i_txf_almost_empty <= 1;
        rd(8'h14, 32'h9a02);
        acc(1'b1, 8'h14, 32'h1);
        rd(8'h14, 32'h8a02);
        // serial receiver: one word stored while enabled, refused once disabled
        acc(1'b1, 8'h0c, 32'h1);
        chk("rx enable", o_rx_enable, 1);
        @(posedge i_ref_clk) {i_rx_word_valid, i_rx_word} <= {1'b1, 18'h1_2345};
        @(posedge i_ref_clk) i_rx_word_valid <= 0;
        rd(8'h18, 32'h5);
        acc(1'b1, 8'h0c, 32'h0);
        chk("rx ready", o_rx_word_ready, 0);
        rd(8'h18, 32'h5);
        test_done();
    end
endmodule : ssrx_regs_test
